// >>> rtl/lcs_clkdiv.v
// Enable-pulse divider that also toggles a square clock output.
// Assumes a single clock; the output flips once per enable pulse.
module lcs_clkdiv #(
  parameter WIDTH = 8
) (
  input  wire             clock_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] half_period_i,
  output reg              tick_o,
  output reg              clk_o
);
  reg [WIDTH-1:0] count;

  // A half period of zero is treated as one so the output still toggles.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      count  <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
      clk_o  <= 1'b0;
    end else if (count + 1'b1 >= half_period_i) begin
      count  <= {WIDTH{1'b0}};
      tick_o <= 1'b1;
      clk_o  <= ~clk_o;
    end else begin
      count  <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> rtl/lcs_map.vh
// Constants for the second-level cache strobe and clock generator.
// Assumes inclusion by bare name from the design files of this block.
`ifndef LCS_MAP_VH
`define LCS_MAP_VH
`define LCS_TAG_ADDR_MSB   6
`define LCS_TAG_VALID_BIT  7
`define LCS_TAG_WIDTH      8
`define LCS_ADDR_TAG_HI    23
`define LCS_ADDR_TAG_LO    17
`define LCS_CPU_OLD        1'b0
`define LCS_CPU_NEW        1'b1
`define LCS_MODE_ASYNC     1'b0
`define LCS_MODE_SYNC      1'b1
`define LCS_SYS_DIV_RESET  8'h02
`define LCS_ST_IDLE        3'h0
`define LCS_ST_RD_TAG      3'h1
`define LCS_ST_RD_DATA     3'h2
`define LCS_ST_WR          3'h3
`define LCS_ST_WR_DONE     3'h4
`endif

// >>> rtl/lcs_sync2.v
// Two-stage synchroniser for one level arriving from a pin.
// Assumes the level may change at any time relative to clock_i.
module lcs_sync2 (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire level_i,
  output reg  level_o
);
  reg meta;

  // The first stage feeds only the second stage.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta    <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta    <= level_i;
      level_o <= meta;
    end
  end
endmodule

// >>> rtl/lcs_top.v
// Second-level cache strobes, tag bus handling and clock generation.
// Assumes clock_i is the internal 50 MHz clock; the reset drive, hold ack and
// oscillator pins are asynchronous to it and synchronised before use. The pin cpu_2x_osc_in is sampled
// as a level, so its rate must stay well below half of clock_i.
`include "lcs_map.vh"

module lcs_top #(
  parameter       SYS_DIV_W = 8,
  parameter [7:0] SYS_HALF  = `LCS_SYS_DIV_RESET
) (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        cpu_new_type_i,
  input  wire        lookup_req_i,
  input  wire        write_req_i,
  input  wire [31:0] host_addr_i,
  input  wire [3:0]  host_byte_en_n_i,
  input  wire        tag_bus_i,
  input  wire [7:0]  tag_bus_in_i,
  input  wire        system_reset_drive_i,
  input  wire        sys_hold_ack_i,
  input  wire        sys_osc_or_clk_in_i,
  input  wire        cpu_2x_osc_in_i,
  input  wire        shared_a_in_i,
  input  wire        shared_b_in_i,
  output reg         cache_wr_en_low_half_n_o,
  output reg         cache_wr_en_high_half_n_o,
  output reg         tag_ram_out_en_n_o,
  output reg         l2_data_out_en_n_o,
  output reg  [7:0]  tag_bus_o,
  output reg         tag_bus_oe_o,
  output reg         hit_o,
  output reg         done_o,
  output reg         sys_osc_or_clk_out_o,
  output reg         sys_osc_or_clk_out_oe_o,
  output reg         sys_timing_o,
  output reg         sync_mode_o,
  output reg         cpu_clk_out_o,
  output reg         shared_func_o
);
  wire       rst_drv_s;
  wire       hold_ack_s;
  wire       osc_s;
  wire       cpu_2x_osc_in_s;
  wire       unused_tag_flag;
  wire       div_tick;
  wire       div_clk;
  reg        rst_drv_d;
  reg        cpu_2x_osc_in_d;
  reg        half_clk;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [7:0] tag_latch;

  assign unused_tag_flag = tag_bus_i;

  // Every pin from outside the clock domain is brought in through two flops.
  lcs_sync2 u_sync_rst (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (system_reset_drive_i),
    .level_o   (rst_drv_s)
  );
  lcs_sync2 u_sync_hlda (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (sys_hold_ack_i),
    .level_o   (hold_ack_s)
  );
  lcs_sync2 u_sync_osc (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (sys_osc_or_clk_in_i),
    .level_o   (osc_s)
  );
  lcs_sync2 u_sync_cpu_2x_osc_in (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (cpu_2x_osc_in_i),
    .level_o   (cpu_2x_osc_in_s)
  );

  // Synchronous-mode clock out is a divided copy of the internal clock.
  lcs_clkdiv #(
    .WIDTH (SYS_DIV_W)
  ) u_sys_div (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .half_period_i (SYS_HALF),
    .tick_o        (div_tick),
    .clk_o         (div_clk)
  );

  // The mode strap is caught on the falling edge of the system reset.
  // Sampling after synchronisation costs two cycles but avoids metastability.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      rst_drv_d   <= 1'b0;
      sync_mode_o <= `LCS_MODE_ASYNC;
    end else begin
      rst_drv_d <= rst_drv_s;
      if (rst_drv_d && !rst_drv_s)
        sync_mode_o <= hold_ack_s;
    end
  end

  // The shared pin is an input in async mode and a driven clock otherwise.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      sys_osc_or_clk_out_o    <= 1'b0;
      sys_osc_or_clk_out_oe_o <= 1'b0;
      sys_timing_o            <= 1'b0;
    end else if (sync_mode_o == `LCS_MODE_SYNC) begin
      sys_osc_or_clk_out_o    <= div_clk;
      sys_osc_or_clk_out_oe_o <= 1'b1;
      sys_timing_o            <= div_clk;
    end else begin
      sys_osc_or_clk_out_o    <= 1'b0;
      sys_osc_or_clk_out_oe_o <= 1'b0;
      sys_timing_o            <= osc_s;
    end
  end

  // The processor clock is buffered or halved from the 2X oscillator.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      cpu_2x_osc_in_d        <= 1'b0;
      half_clk      <= 1'b0;
      cpu_clk_out_o <= 1'b0;
    end else begin
      cpu_2x_osc_in_d <= cpu_2x_osc_in_s;
      if (cpu_2x_osc_in_s && !cpu_2x_osc_in_d)
        half_clk <= ~half_clk;
      if (cpu_new_type_i == `LCS_CPU_NEW)
        cpu_clk_out_o <= half_clk;
      else
        cpu_clk_out_o <= cpu_2x_osc_in_s;
    end
  end

  // Shared processor pins present one function per processor family.
  always @(posedge clock_i) begin
    if (!reset_n_i)
      shared_func_o <= 1'b0;
    else if (cpu_new_type_i == `LCS_CPU_NEW)
      shared_func_o <= shared_b_in_i;
    else
      shared_func_o <= shared_a_in_i;
  end

  // Cache access sequencer: lookup reads tag then data, write fills both.
  always @* begin
    next_state = state;
    case (state)
      `LCS_ST_IDLE: begin
        if (write_req_i)
          next_state = `LCS_ST_WR;
        else if (lookup_req_i)
          next_state = `LCS_ST_RD_TAG;
      end
      `LCS_ST_RD_TAG:  next_state = `LCS_ST_RD_DATA;
      `LCS_ST_RD_DATA: next_state = `LCS_ST_IDLE;
      `LCS_ST_WR:      next_state = `LCS_ST_WR_DONE;
      `LCS_ST_WR_DONE: next_state = `LCS_ST_IDLE;
      default:         next_state = `LCS_ST_IDLE;
    endcase
  end

  // Strobes are registered so the SRAM sees clean, glitch-free edges.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      state                     <= `LCS_ST_IDLE;
      tag_latch                 <= 8'h00;
      cache_wr_en_low_half_n_o  <= 1'b1;
      cache_wr_en_high_half_n_o <= 1'b1;
      tag_ram_out_en_n_o        <= 1'b1;
      l2_data_out_en_n_o        <= 1'b1;
      tag_bus_o                 <= 8'h00;
      tag_bus_oe_o              <= 1'b0;
      hit_o                     <= 1'b0;
      done_o                    <= 1'b0;
    end else begin
      state  <= next_state;
      done_o <= 1'b0;
      tag_ram_out_en_n_o        <= 1'b1;
      l2_data_out_en_n_o        <= 1'b1;
      cache_wr_en_low_half_n_o  <= 1'b1;
      cache_wr_en_high_half_n_o <= 1'b1;
      tag_bus_oe_o              <= 1'b0;
      // Tag field and valid bit are built the same way for write and compare.
      tag_latch <= {1'b1,
        host_addr_i[`LCS_ADDR_TAG_HI:`LCS_ADDR_TAG_LO]};
      case (next_state)
        `LCS_ST_RD_TAG: begin
          tag_ram_out_en_n_o <= 1'b0;
        end
        `LCS_ST_RD_DATA: begin
          l2_data_out_en_n_o <= 1'b0;
          // A hit needs a matching address field and the valid bit set.
          hit_o <= tag_bus_in_i[`LCS_TAG_VALID_BIT] &&
            (tag_bus_in_i[`LCS_TAG_ADDR_MSB:0] ==
             tag_latch[`LCS_TAG_ADDR_MSB:0]);
        end
        `LCS_ST_WR: begin
          tag_bus_o    <= {1'b1,
            host_addr_i[`LCS_ADDR_TAG_HI:`LCS_ADDR_TAG_LO]};
          tag_bus_oe_o <= 1'b1;
          cache_wr_en_low_half_n_o <=
            &host_byte_en_n_i[1:0];
          cache_wr_en_high_half_n_o <=
            &host_byte_en_n_i[3:2];
        end
        `LCS_ST_WR_DONE: begin
          tag_bus_oe_o <= 1'b1;
        end
        `LCS_ST_IDLE: begin
          done_o <= (state != `LCS_ST_IDLE);
        end
        default: begin
          done_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> test/lcs_tag_sram.sv
// Tag SRAM model with one entry, written by a strobe while tags are driven.
// Assumes the tag bus holds no value while its output enable is off.
module lcs_tag_sram (
  input  logic       clock_i,
  input  logic       clear_i,
  input  logic       we_lo_n_i,
  input  logic       we_hi_n_i,
  input  logic       oe_n_i,
  input  logic       drv_i,
  input  logic [7:0] wr_i,
  output logic [7:0] rd_o
);
  logic [7:0] mem = 8'h00;
  logic [7:0] last = 8'h00;
  // Clearing drops only the valid bit and leaves a stale address behind.
  always @(posedge clock_i) begin
    if (clear_i) mem[7] <= 1'b0;
    else if (drv_i && !(we_lo_n_i && we_hi_n_i)) mem <= wr_i;
    if (!oe_n_i) last <= mem;
  end
  // A released bus shows the inverse of its last value, never a held copy.
  assign rd_o = oe_n_i ? ~last : mem;
endmodule

// >>> test/lcs_top_asserts.sv
// Checker for lcs_top strobes, tag bus and shared pin direction.
// Assumes requests arrive only while the block is idle.
module lcs_chk (
  input logic        clock_i,
  input logic        reset_n_i,
  input logic        lookup_req_i,
  input logic        write_req_i,
  input logic [31:0] host_addr_i,
  input logic [3:0]  host_byte_en_n_i,
  input logic [7:0]  tag_bus_in_i,
  input logic        cache_wr_en_low_half_n_o,
  input logic        cache_wr_en_high_half_n_o,
  input logic        tag_ram_out_en_n_o,
  input logic        l2_data_out_en_n_o,
  input logic [7:0]  tag_bus_o,
  input logic        tag_bus_oe_o,
  input logic        hit_o,
  input logic        done_o,
  input logic        sys_osc_or_clk_out_oe_o,
  input logic        sync_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [1:0] cnt;
  logic [3:0] be;
  logic [6:0] addr;
  logic [7:0] seen;
  wire acc = cnt == 2'h0 && (write_req_i || lookup_req_i);
  wire wr = acc && write_req_i;
  wire rd = acc && !write_req_i;
  wire lo = cache_wr_en_low_half_n_o;
  wire hi = cache_wr_en_high_half_n_o;
  // The busy count keeps a held request from looking like a second one.
  // It reaches zero at the edge where the block is idle again, so a request
  // held through the done cycle is seen exactly when the block takes it.
  always @(posedge clock_i) begin
    if (!reset_n_i) cnt <= 2'h0;
    else if (acc) cnt <= 2'h2;
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    if (acc) addr <= host_addr_i[23:17];
    if (acc) be <= host_byte_en_n_i;
    if (!tag_ram_out_en_n_o) seen <= tag_bus_in_i;
  end
  a_low_strobe: assert property (wr |=> lo == &be[1:0])
    else $error("low write strobe wrong");
  a_high_strobe: assert property (wr |=> hi == &be[3:2])
    else $error("high write strobe wrong");
  a_strobe_once: assert property (wr |=> ##1 (lo && hi)[*2])
    else $error("write strobe too long");
  a_no_rd_strobe: assert property (rd |=> (lo && hi)[*3])
    else $error("write strobe during lookup");
  a_read_enables: assert property (rd |=> !tag_ram_out_en_n_o ##1
    (tag_ram_out_en_n_o && !l2_data_out_en_n_o) ##1 l2_data_out_en_n_o)
    else $error("read enable sequence wrong");
  a_tag_drive: assert property (wr |=>
    (tag_bus_oe_o && tag_bus_o == {1'b1, addr})[*2] ##1 !tag_bus_oe_o)
    else $error("tag drive wrong");
  a_hit_calc: assert property (rd |=> ##2
    hit_o == (seen[7] && seen[6:0] == addr))
    else $error("hit wrong");
  a_done_time: assert property (acc |=> !done_o ##1 !done_o ##1 done_o)
    else $error("done timing wrong");
  a_pin_dir: assert property ($stable(sync_mode_o) |->
    sys_osc_or_clk_out_oe_o == sync_mode_o)
    else $error("shared pin direction wrong");
  c_write: cover property (wr);
  c_hit: cover property (rd ##3 hit_o);
  c_sync: cover property ($rose(sync_mode_o));
endmodule

bind lcs_top lcs_chk u_chk (.*);

// >>> test/tb_lcs_top.sv
// Self-checking bench for lcs_top with a tag SRAM model on the tag bus.
// Assumes default parameters: the sync clock half period is 2 cycles.
module tb_lcs_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); \
    end end
  logic        clock_i = 0, reset_n_i = 0, cpu_new_type_i = 0, clr = 0;
  logic        lookup_req_i = 0, write_req_i = 0, tag_bus_i = 0;
  logic [31:0] host_addr_i = 32'h0000_0000, a;
  logic [3:0]  host_byte_en_n_i = 4'hf;
  logic        system_reset_drive_i = 1, sys_hold_ack_i = 0;
  logic        sys_osc_or_clk_in_i = 0, cpu_2x_osc_in_i = 0;
  logic        shared_a_in_i = 0, shared_b_in_i = 0;
  wire  [7:0]  tag_bus_in_i, tag_bus_o;
  wire         cache_wr_en_low_half_n_o, cache_wr_en_high_half_n_o;
  wire         tag_ram_out_en_n_o, l2_data_out_en_n_o, tag_bus_oe_o;
  wire         hit_o, done_o, sys_osc_or_clk_out_o, sys_osc_or_clk_out_oe_o;
  wire         sys_timing_o, sync_mode_o, cpu_clk_out_o, shared_func_o;
  int          miscompares = 0, n_compared = 0, cyc = 0, n_cpu, n_sys, n_tim;
  int          seed = 32'h55aa_5a01;
  logic [7:0]  st_tag = 8'h00;
  logic [11:0] expq[$], q;
  logic [9:0]  cap;
  logic        exp_hit = 0, oe_d = 0;
  logic [3:0]  be_tab[6] = '{4'hf, 4'hc, 4'h3, 4'h7, 4'he, 4'h0};
  lcs_top dut (.*);
  lcs_tag_sram u_sram (.clock_i(clock_i), .clear_i(clr),
    .we_lo_n_i(cache_wr_en_low_half_n_o), .drv_i(tag_bus_oe_o),
    .we_hi_n_i(cache_wr_en_high_half_n_o), .oe_n_i(tag_ram_out_en_n_o),
    .wr_i(tag_bus_o), .rd_o(tag_bus_in_i));
  initial forever #10 clock_i = ~clock_i;
  // Slow pin oscillators, so a sampled copy can follow them exactly.
  always @(posedge clock_i) begin
    cyc++;
    #1;
    if (cyc % 5 == 0) cpu_2x_osc_in_i = ~cpu_2x_osc_in_i;
    if (cyc % 7 == 0) sys_osc_or_clk_in_i = ~sys_osc_or_clk_in_i;
  end
  always @(posedge cpu_clk_out_o) n_cpu++;
  always @(posedge sys_osc_or_clk_out_o) n_sys++;
  always @(posedge sys_timing_o) n_tim++;
  function automatic logic near(int n, int x);
    return n >= x - 1 && n <= x + 1;
  endfunction
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // The run needs about 1400 cycles; the ceiling only catches a hang.
  initial begin
    wait (cyc == 6000);
    miscompares++;
    conclude();
  end
  // Each result is matched in order against the note left by access.
  always @(posedge clock_i) begin
    if (tag_bus_oe_o === 1'b1 && !oe_d)
      cap = {cache_wr_en_high_half_n_o, cache_wr_en_low_half_n_o, tag_bus_o};
    oe_d = tag_bus_oe_o;
    if (done_o === 1'b1) begin
      q = expq.pop_front();
      `CMP(hit_o, q[10])
      if (q[11]) `CMP(cap, q[9:0])
    end
  end
  task automatic access(input logic wr, input logic [31:0] ad,
                        input logic [3:0] be);
    if (wr && be != 4'hf) st_tag = {1'b1, ad[23:17]};
    if (!wr) exp_hit = st_tag[7] && st_tag[6:0] == ad[23:17];
    expq.push_back({wr, exp_hit, &be[3:2], &be[1:0], 1'b1, ad[23:17]});
    @(posedge clock_i) #1;
    write_req_i = wr;
    lookup_req_i = !wr;
    host_addr_i = ad;
    host_byte_en_n_i = be;
    @(posedge clock_i) #1;
    write_req_i = 0;
    lookup_req_i = 0;
    repeat (3) @(posedge clock_i);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    #1 reset_n_i = 1;
    repeat (2) @(posedge clock_i);
    #1 system_reset_drive_i = 0;
    // Six enable patterns, each followed by a matching and a near lookup.
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      access(1, a, be_tab[i]);
      access(0, a, 4'hf);
      access(0, a ^ 32'h0002_0000, 4'hf);
    end
    @(posedge clock_i) #1 clr = 1;
    st_tag[7] = 0;
    @(posedge clock_i) #1 clr = 0;
    access(0, a, 4'hf);
    $display("test cache done");
    for (int t = 0; t < 2; t++) begin
      #1 cpu_new_type_i = t[0];
      {shared_a_in_i, shared_b_in_i} = 2'($random(seed));
      repeat (20) @(posedge clock_i);
      n_cpu = 0;
      n_tim = 0;
      repeat (420) @(posedge clock_i);
      `CMP(near(n_cpu, t ? 21 : 42), 1'b1)
      `CMP(shared_func_o, t ? shared_b_in_i : shared_a_in_i)
      `CMP(near(n_tim, 30), 1'b1)
      `CMP(sys_osc_or_clk_out_oe_o, 1'b0)
    end
    $display("test clocks done");
    #1 sys_hold_ack_i = 1;
    system_reset_drive_i = 1;
    repeat (4) @(posedge clock_i);
    #1 system_reset_drive_i = 0;
    repeat (4) @(posedge clock_i);
    #1 sys_hold_ack_i = 0;
    n_sys = 0;
    repeat (400) @(posedge clock_i);
    `CMP(sync_mode_o, 1'b1)
    `CMP(sys_osc_or_clk_out_oe_o, 1'b1)
    `CMP(near(n_sys, 100), 1'b1)
    #1 system_reset_drive_i = 1;
    repeat (4) @(posedge clock_i);
    #1 system_reset_drive_i = 0;
    repeat (4) @(posedge clock_i);
    `CMP(sync_mode_o, 1'b0)
    $display("test strap done");
    conclude();
  end
endmodule
